// [hw/hpser_pkg.sv]
// Package of offsets, field positions and reset values for the slot event reporting block
package hpser_pkg;
   localparam logic [7:0] INT_LOCATOR_OFS = 8'h18;
   localparam logic [7:0] ERR_LOCATOR_OFS = 8'h1c;
   localparam logic [7:0] CTRL_MASK_OFS = 8'h20;
   localparam logic [7:0] SLOT_CTRL_OFS = 8'h24;
   localparam logic [7:0] CMD_OFS = 8'h14;
   localparam logic [7:0] CMD_STATUS_OFS = 8'h16;
   // Controller event mask register fields
   localparam int ARB_DET_BIT = 17;
   localparam int CMD_DET_BIT = 16;
   localparam int ARB_SERR_MASK_BIT = 3;
   localparam int CMD_INT_MASK_BIT = 2;
   localparam int GLB_SERR_MASK_BIT = 1;
   localparam int GLB_INT_MASK_BIT = 0;
   localparam logic [3:0] CTRL_MASK_RESET = 4'hf;
   // Slot register fields
   localparam int SLOT_SERR_MASK_LO = 29;
   localparam logic [1:0] SLOT_SERR_MASK_RESET = 2'h3;
   localparam int SLOT_INT_MASK_LO = 24;
   localparam logic [4:0] SLOT_INT_MASK_RESET = 5'h1f;
   localparam int SLOT_EVENT_LO = 16;
   localparam int EV_PRESENCE = 0;
   localparam int EV_ISO_FAULT = 1;
   localparam int EV_ATTN = 2;
   localparam int EV_LATCH = 3;
   localparam int EV_CONN_FAULT = 4;
   // Locator fields
   localparam int LOC_SLOT_BIT = 1;
   localparam int LOC_CTRL_BIT = 0;
   // Command execution time in cycles
   localparam int CMD_BUSY_CYCLES = 16;
endpackage

// [hw/hpser_cap_reg.sv]
// Capture register for the card speed capability sampled at power-up or enable
`timescale 1ns/1ns
`default_nettype none
module hpser_cap_reg #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic capture,
   input wire logic [WIDTH-1:0] dataIn,
   output logic [WIDTH-1:0] dataOut
);
   logic [WIDTH-1:0] hold_ff;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hold_ff <= '0;
      end else if (capture) begin
         hold_ff <= dataIn;
      end
   end
   assign dataOut = hold_ff;
endmodule
`default_nettype wire

// [hw/hpser_event_report.sv]
// Event latching, masking and locator logic for one hot-plug slot
//
// Notes on behaviour
// - Slot locator bit on unmasked latched event
// - Slot locator clears when event latches clear
// - Locator bit 0 is unmasked command complete
// - Error locator slot bit from unmasked SERR events
// - Error locator bit 0 is unmasked arbiter time-out
// - Arbiter time-out flag sets regardless of masks
// - Completion flag sets on busy falling edge
// - Nonfatal message needs both masks clear, enable
// - Command interrupt mask bit 2, resets set
// - Global SERR mask bit 1 suppresses errors
// - Global interrupt mask gates interrupt only
// - Slot SERR masks bits 30, 29 for fatal
// - Slot interrupt masks bits 28..24, reset masked
// - Latch power faults and latch sensor changes
// - Attention press latched on rising edge only
// - Presence change latched on any pin change
// - Card capability reported in bits 13:12
// - Presence pin pair reported in bits 11:10
// - 66 MHz capability captured at power-up
// - Live latch, button, fault status bits
// - Indicator states in bits 5:4, 3:2
// - Slot state reported in bits 1:0
// - Busy holds during command; writes ignored
`timescale 1ns/1ns
`default_nettype none
module hpser_event_report
   import hpser_pkg::*;
#(
   parameter int BUSY_CYCLES = hpser_pkg::CMD_BUSY_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic [3:0] regByteEn,
   output logic [31:0] regRdata,
   input wire logic arbTimeout,
   input wire logic connPowerFault,
   input wire logic isoPowerFault,
   input wire logic retentionLatchOpen,
   input wire logic attnButton,
   input wire logic [1:0] presencePins,
   input wire logic [1:0] cardCapability,
   input wire logic card66Capable,
   input wire logic [1:0] attnIndicator,
   input wire logic [1:0] powerIndicator,
   input wire logic [1:0] slotState,
   input wire logic serrEnable,
   input wire logic fatalReportEn,
   input wire logic nonfatalReportEn,
   output logic sysInterrupt,
   output logic errFatalMsg,
   output logic errNonfatalMsg,
   output logic cmdBusy
);
   import hpser_pkg::*;

   // ****************************************************
   // State
   // ****************************************************
   logic arbDet_ff, cmdDet_ff;
   logic [3:0] ctrlMask_ff;
   logic [1:0] slotSerrMask_ff;
   logic [4:0] slotIntMask_ff;
   logic [4:0] slotEvent_ff;
   logic [7:0] cmdCode_ff;
   logic [4:0] cmdSlot_ff;
   logic [$clog2(BUSY_CYCLES+1)-1:0] busyCnt_ff;
   logic busy_ff;
   logic prevLatch_ff, prevAttn_ff;
   logic [1:0] prevPresence_ff;
   logic [31:0] rdata_ff;
   logic fatalPend_ff, nonfatalPend_ff;
   logic [1:0] prevSlotState_ff;
   logic cap66;

   function automatic logic [31:0] wmask(input logic [3:0] be);
      wmask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // ****************************************************
   // Decode
   // ****************************************************
   wire logic [31:0] bitWr = regWdata & wmask(regByteEn);
   wire logic wrCtrl = regWrite && regAddr == CTRL_MASK_OFS;
   wire logic wrSlot = regWrite && regAddr == SLOT_CTRL_OFS;
   wire logic wrCmd = regWrite && regAddr == CMD_OFS && regByteEn[0];
   wire logic cmdStart = wrCmd && !busy_ff;
   wire logic busyFall = busy_ff && busyCnt_ff == 1;

   // Event detection from the current and previous debounced inputs
   wire logic [4:0] evSet;
   assign evSet[EV_CONN_FAULT] = connPowerFault;
   assign evSet[EV_ISO_FAULT] = isoPowerFault;
   assign evSet[EV_LATCH] = retentionLatchOpen != prevLatch_ff;
   assign evSet[EV_ATTN] = attnButton && !prevAttn_ff;
   assign evSet[EV_PRESENCE] = presencePins != prevPresence_ff;

   // Set wins over a clearing write in the same cycle
   wire logic [4:0] evClr = wrSlot ? bitWr[SLOT_EVENT_LO +: 5] : 5'h00;
   wire logic [4:0] nxt_slotEvent = (slotEvent_ff & ~evClr) | evSet;
   wire logic nxt_arbDet = (arbDet_ff && !(wrCtrl && bitWr[ARB_DET_BIT])) || arbTimeout;
   wire logic nxt_cmdDet = (cmdDet_ff && !(wrCtrl && bitWr[CMD_DET_BIT])) || busyFall;

   // ****************************************************
   // Locators and outgoing requests
   // ****************************************************
   wire logic slotIntPend = |(slotEvent_ff & ~slotIntMask_ff);
   wire logic cmdIntPend = cmdDet_ff && !ctrlMask_ff[CMD_INT_MASK_BIT];
   wire logic [1:0] serrEvents = {slotEvent_ff[EV_CONN_FAULT], slotEvent_ff[EV_LATCH]};
   wire logic slotSerrPend = |(serrEvents & ~slotSerrMask_ff);
   wire logic arbSerrPend = arbDet_ff && !ctrlMask_ff[ARB_SERR_MASK_BIT];
   wire logic [31:0] intLoc = {30'h0, slotIntPend, cmdIntPend};
   wire logic [31:0] errLoc = {30'h0, slotSerrPend, arbSerrPend};
   wire logic glbSerrOk = !ctrlMask_ff[GLB_SERR_MASK_BIT];
   wire logic nxt_fatalPend = slotSerrPend && glbSerrOk && (serrEnable || fatalReportEn);
   wire logic nxt_nonfatalPend = arbSerrPend && glbSerrOk
                                 && (serrEnable || nonfatalReportEn);

   // Interrupt is a level while any locator bit stands and global mask is clear
   assign sysInterrupt = |intLoc && !ctrlMask_ff[GLB_INT_MASK_BIT];
   // Messages are one-cycle pulses on the rising edge of the pending condition
   assign errFatalMsg = nxt_fatalPend && !fatalPend_ff;
   assign errNonfatalMsg = nxt_nonfatalPend && !nonfatalPend_ff;
   assign cmdBusy = busy_ff;

   // ****************************************************
   // Capability capture
   // ****************************************************
   wire logic poweredUp = slotState != prevSlotState_ff && (slotState == 2'h1 || slotState == 2'h2);
   hpser_cap_reg #(.WIDTH(1)) u_cap66 (
      .clk_sys(clk_sys),
      .reset(reset),
      .capture(poweredUp),
      .dataIn(card66Capable),
      .dataOut(cap66)
   );

   wire logic [31:0] slotWord = {1'b0, slotSerrMask_ff, slotIntMask_ff, 3'h0, slotEvent_ff,
                                 2'h0, cardCapability, presencePins, cap66,
                                 retentionLatchOpen, attnButton,
                                 connPowerFault | isoPowerFault,
                                 attnIndicator, powerIndicator, slotState};
   wire logic [31:0] ctrlWord = {14'h0, arbDet_ff, cmdDet_ff, 12'h0, ctrlMask_ff};
   wire logic [31:0] cmdWord = {15'h0, busy_ff, 3'h0, cmdSlot_ff, cmdCode_ff};

   logic [31:0] nxt_rdata;
   always_comb begin
      case (regAddr)
         INT_LOCATOR_OFS: nxt_rdata = intLoc;
         ERR_LOCATOR_OFS: nxt_rdata = errLoc;
         CTRL_MASK_OFS: nxt_rdata = ctrlWord;
         SLOT_CTRL_OFS: nxt_rdata = slotWord;
         CMD_OFS: nxt_rdata = cmdWord;
         default: nxt_rdata = 32'h0;
      endcase
   end
   assign regRdata = rdata_ff;

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         arbDet_ff <= 1'b0;
         cmdDet_ff <= 1'b0;
         slotEvent_ff <= 5'h00;
         fatalPend_ff <= 1'b0;
         nonfatalPend_ff <= 1'b0;
         rdata_ff <= 32'h0;
      end else begin
         arbDet_ff <= nxt_arbDet;
         cmdDet_ff <= nxt_cmdDet;
         slotEvent_ff <= nxt_slotEvent;
         fatalPend_ff <= nxt_fatalPend;
         nonfatalPend_ff <= nxt_nonfatalPend;
         if (regRead) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrlMask_ff <= CTRL_MASK_RESET;
         slotSerrMask_ff <= SLOT_SERR_MASK_RESET;
         slotIntMask_ff <= SLOT_INT_MASK_RESET;
      end else begin
         if (wrCtrl && regByteEn[0]) begin
            ctrlMask_ff <= regWdata[3:0];
         end
         if (wrSlot && regByteEn[3]) begin
            slotSerrMask_ff <= regWdata[SLOT_SERR_MASK_LO +: 2];
            slotIntMask_ff <= regWdata[SLOT_INT_MASK_LO +: 5];
         end
      end
   end

   // Previous-value registers have no reset and track the inputs during reset as well
   always_ff @(posedge clk_sys) begin
      prevLatch_ff <= retentionLatchOpen;
      prevAttn_ff <= attnButton;
      prevPresence_ff <= presencePins;
      prevSlotState_ff <= slotState;
   end

   // Command execution is modelled as a fixed busy time
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         busy_ff <= 1'b0;
         busyCnt_ff <= '0;
         cmdCode_ff <= 8'h00;
         cmdSlot_ff <= 5'h00;
      end else if (cmdStart) begin
         busy_ff <= 1'b1;
         busyCnt_ff <= ($clog2(BUSY_CYCLES+1))'(BUSY_CYCLES);
         cmdCode_ff <= regWdata[7:0];
         if (regByteEn[1]) begin
            cmdSlot_ff <= regWdata[12:8];
         end
      end else if (busy_ff) begin
         busyCnt_ff <= busyCnt_ff - 1'b1;
         busy_ff <= !busyFall;
      end
   end
endmodule
`default_nettype wire

// [test/hpser_event_report_asserts.sv]
// Port-level checker of the slot event reporting block
`timescale 1ns/1ns
`default_nettype none
module hpser_event_report_asserts
   import hpser_pkg::*;
#(
   parameter int BUSY_CYCLES = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [3:0] regByteEn,
   input wire logic [31:0] regRdata,
   input wire logic serrEnable,
   input wire logic fatalReportEn,
   input wire logic nonfatalReportEn,
   input wire logic sysInterrupt,
   input wire logic errFatalMsg,
   input wire logic errNonfatalMsg,
   input wire logic cmdBusy
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ****************
   // Busy span
   // ****************
   // A write during busy is ignored and cannot restart the span, so this count peaks at BUSY_CYCLES
   logic [7:0] busyCnt_ff;
   always_ff @(posedge clk_sys) begin
      busyCnt_ff <= (reset || !cmdBusy) ? 8'h00 : busyCnt_ff + 8'h01;
   end
   sequence cmdWr;
      regWrite && regAddr == CMD_OFS && regByteEn[0] && !cmdBusy;
   endsequence
   a_busy_start: assert property (cmdWr |=> cmdBusy)
      else $error("busy missing");
   a_busy_span: assert property (busyCnt_ff <= BUSY_CYCLES + 1)
      else $error("busy too long");
   a_reset_quiet: assert property ($fell(reset) |-> !sysInterrupt && !errFatalMsg)
      else $error("output after reset");
   a_rdata_hold: assert property (!$past(regRead) && !$past(reset) |-> $stable(regRdata))
      else $error("read data moved");
   a_loc_reserved: assert property (regRead && regAddr[7:3] == 5'h03 |=> regRdata[31:2] == 30'h0)
      else $error("locator reserved bits");
   a_unmapped_zero: assert property (regRead && regAddr == 8'h40 |=> regRdata == 32'h0)
      else $error("unmapped read");
   a_fatal_gate: assert property (errFatalMsg |-> serrEnable || fatalReportEn)
      else $error("fatal without enable");
   a_nonfatal_gate: assert property (errNonfatalMsg |-> serrEnable || nonfatalReportEn)
      else $error("nonfatal without enable");
   a_msg_pulse: assert property (errNonfatalMsg |=> !errNonfatalMsg)
      else $error("message not a pulse");
   a_fatal_pulse: assert property (errFatalMsg |=> !errFatalMsg)
      else $error("fatal message not a pulse");
endmodule
`default_nettype wire

// [test/hpser_slot_model.sv]
// Behavioural slot hardware delivering debounced sensor and fault levels
`timescale 1ns/1ns
`default_nettype none
module hpser_slot_model (
   input wire logic clk_sys,
   input wire logic [5:0] want,
   output logic connPowerFault,
   output logic isoPowerFault,
   output logic retentionLatchOpen,
   output logic attnButton,
   output logic [1:0] presencePins
);
   // Debounced levels move only just after an edge
   always_ff @(posedge clk_sys) begin
      {connPowerFault, isoPowerFault, retentionLatchOpen, attnButton, presencePins} <= want;
   end
endmodule
`default_nettype wire

// [test/test_hpser_event_report.sv]
// Self-checking bench for the slot event reporting block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_hpser_event_report;
   import hpser_pkg::*;
   logic clk_sys = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, arbTimeout = 1'b0;
   logic serrEnable = 1'b0, fatalReportEn = 1'b1, nonfatalReportEn = 1'b1, b9 = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0, regRdata;
   logic [3:0] regByteEn = 4'hf;
   logic [1:0] cardCapability = 2'h1, attnIndicator = 2'h2, slotState = 2'h3, presencePins;
   logic [5:0] want = 6'h03;
   logic connPowerFault, isoPowerFault, retentionLatchOpen, attnButton;
   logic sysInterrupt, errFatalMsg, errNonfatalMsg, cmdBusy;
   int mismatches = 0, checked = 0, fatalCnt = 0, nonfatalCnt = 0, n;
   hpser_slot_model slot_u (.clk_sys(clk_sys), .want(want), .connPowerFault(connPowerFault),
      .isoPowerFault(isoPowerFault), .retentionLatchOpen(retentionLatchOpen),
      .attnButton(attnButton), .presencePins(presencePins));
   hpser_event_report #(.BUSY_CYCLES(4)) dut_u (.clk_sys(clk_sys), .reset(reset),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
      .regByteEn(regByteEn), .regRdata(regRdata), .arbTimeout(arbTimeout),
      .connPowerFault(connPowerFault), .isoPowerFault(isoPowerFault),
      .retentionLatchOpen(retentionLatchOpen), .attnButton(attnButton),
      .presencePins(presencePins), .cardCapability(cardCapability), .card66Capable(1'b1),
      .attnIndicator(attnIndicator), .powerIndicator(2'h1), .slotState(slotState),
      .serrEnable(serrEnable), .fatalReportEn(fatalReportEn),
      .nonfatalReportEn(nonfatalReportEn), .sysInterrupt(sysInterrupt),
      .errFatalMsg(errFatalMsg), .errNonfatalMsg(errNonfatalMsg), .cmdBusy(cmdBusy));
   initial forever #20 clk_sys = ~clk_sys;
   // Message outputs are combinational, so count them away from the edge
   always @(negedge clk_sys) begin
      fatalCnt += (errFatalMsg === 1'b1);
      nonfatalCnt += (errNonfatalMsg === 1'b1);
   end
   function automatic logic [31:0] slotExp(input logic [6:0] m, input logic [4:0] ev);
      return {1'b0, m, 3'h0, ev, 2'h0, cardCapability, presencePins, b9, retentionLatchOpen,
         attnButton, connPowerFault | isoPowerFault, attnIndicator, 2'h1, slotState};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      regByteEn <= be;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRead <= 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK(regRdata, e)
   endtask
   task automatic slot(input logic [5:0] v);
      @(posedge clk_sys);
      want <= v;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic arb();
      @(posedge clk_sys);
      arbTimeout <= 1'b1;
      @(posedge clk_sys);
      arbTimeout <= 1'b0;
   endtask
   task automatic finish_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      rd(CTRL_MASK_OFS, 32'hf);
      rd(SLOT_CTRL_OFS, slotExp(7'h7f, 5'h00));
      rd(8'h40, 32'h0);
      slot(6'h07);
      wr(SLOT_CTRL_OFS, 32'h7f000000, 4'hf);
      rd(SLOT_CTRL_OFS, slotExp(7'h7f, 5'h04));
      wr(SLOT_CTRL_OFS, 32'h7f040000, 4'hf);
      slot(6'h0b);
      rd(SLOT_CTRL_OFS, slotExp(7'h7f, 5'h08));
      wr(SLOT_CTRL_OFS, 32'h7e080000, 4'hf);
      @(posedge clk_sys);
      cardCapability <= 2'h3;
      slotState <= 2'h2;
      attnIndicator <= 2'h1;
      b9 = 1'b1;
      slot(6'h0a);
      rd(SLOT_CTRL_OFS, slotExp(7'h7e, 5'h01));
      rd(INT_LOCATOR_OFS, 32'h2);
      `CHK(sysInterrupt, 1'b0)
      wr(CTRL_MASK_OFS, 32'he, 4'hf);
      #1 `CHK(sysInterrupt, 1'b1)
      wr(SLOT_CTRL_OFS, 32'h3f010000, 4'hf);
      rd(INT_LOCATOR_OFS, 32'h0);
      @(posedge clk_sys);
      serrEnable <= 1'b1;
      fatalReportEn <= 1'b0;
      slot(6'h32);
      slot(6'h02);
      rd(ERR_LOCATOR_OFS, 32'h2);
      rd(SLOT_CTRL_OFS, slotExp(7'h3f, 5'h1a));
      `CHK(fatalCnt, 0)
      wr(SLOT_CTRL_OFS, 32'h3f1a0000, 4'hf);
      rd(ERR_LOCATOR_OFS, 32'h0);
      wr(CTRL_MASK_OFS, 32'hc, 4'hf);
      slot(6'h22);
      slot(6'h02);
      `CHK(fatalCnt, 1)
      arb();
      rd(CTRL_MASK_OFS, 32'h2000c);
      rd(ERR_LOCATOR_OFS, 32'h2);
      `CHK(nonfatalCnt, 0)
      wr(CTRL_MASK_OFS, 32'h20004, 4'hf);
      n = nonfatalCnt;
      arb();
      rd(ERR_LOCATOR_OFS, 32'h3);
      `CHK(nonfatalCnt, n + 1)
      wr(CMD_OFS, 32'h1, 4'h1);
      #1 `CHK(cmdBusy, 1'b1)
      wr(CMD_OFS, 32'h2, 4'h1);
      for (n = 0; cmdBusy !== 1'b0 && n < 50; n++) @(posedge clk_sys);
      if (n == 50) begin
         mismatches++;
         finish_test();
      end
      rd(CMD_OFS, 32'h1);
      wr(CTRL_MASK_OFS, 32'hf, 4'h0);
      rd(CTRL_MASK_OFS, 32'h30004);
      rd(INT_LOCATOR_OFS, 32'h0);
      wr(CTRL_MASK_OFS, 32'h0, 4'hf);
      rd(INT_LOCATOR_OFS, 32'h1);
      `CHK(sysInterrupt, 1'b1)
      finish_test();
   end
endmodule
bind hpser_event_report hpser_event_report_asserts #(.BUSY_CYCLES(BUSY_CYCLES)) chk_u (
   .clk_sys(clk_sys), .reset(reset), .regWrite(regWrite), .regRead(regRead),
   .regAddr(regAddr), .regByteEn(regByteEn), .regRdata(regRdata), .serrEnable(serrEnable),
   .fatalReportEn(fatalReportEn), .nonfatalReportEn(nonfatalReportEn),
   .sysInterrupt(sysInterrupt), .errFatalMsg(errFatalMsg), .errNonfatalMsg(errNonfatalMsg),
   .cmdBusy(cmdBusy));
`default_nettype wire
